// ### sap_pkg.sv
// Purpose: Shared constants of the serial audio receive/transmit port
// Assumes: pclk at 250 MHz, APB with 32-bit data
// Notes: Byte addresses, field positions, reset values and timing counts
package sap_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IN_MAP = 12'h004;
  localparam logic [11:0] ADDR_OUT_MAP_LO = 12'h008;
  localparam logic [11:0] ADDR_OUT_MAP_HI = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] ADDR_RX_CH0 = 12'h01C;
  localparam logic [11:0] ADDR_RX_CH1 = 12'h020;

  // ==========================================================
  // Control register fields
  localparam int CTRL_SLOT_LSB = 0;
  localparam int CTRL_DATA_LSB = 2;
  localparam int CTRL_ALIGN_LSB = 4;
  localparam int CTRL_SCK_POL = 6;
  localparam int CTRL_EDGE_SEL = 7;
  localparam int CTRL_LSB_FIRST = 8;
  localparam int CTRL_TX_EN = 9;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RESET = 10'h00A;

  // Size codes for slot size and data size
  localparam logic [1:0] SIZE_16 = 2'h0;
  localparam logic [1:0] SIZE_24 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Alignment codes
  localparam logic [1:0] ALIGN_I2S = 2'h0;
  localparam logic [1:0] ALIGN_LEFT = 2'h1;
  localparam logic [1:0] ALIGN_RIGHT = 2'h2;

  // Input map: slot for channel 0 in [3:0], channel 1 in [7:4]
  localparam logic [7:0] IN_MAP_RESET = 8'h10;
  // Output map: four bits per slot, 0 silent, 1 processed ch 1, 2 processed ch 2
  localparam logic [31:0] OUT_MAP_LO_RESET = 32'h0000_0021;
  localparam logic [31:0] OUT_MAP_HI_RESET = 32'h0000_0000;
  localparam logic [3:0] SRC_PROC1 = 4'h1;
  localparam logic [3:0] SRC_PROC2 = 4'h2;

  // Interrupt status bits
  localparam int IRQ_LOCK_LOST = 0;
  localparam int IRQ_INPUT_ERR = 1;
  localparam int IRQ_LOCKED = 2;
  localparam int IRQ_W = 3;

  // ==========================================================
  // Timing
  localparam int PCLK_KHZ = 250000;
  localparam int BCLK_MAX_KHZ = 24576;
  localparam int BCLK_MIN_CYC = PCLK_KHZ / BCLK_MAX_KHZ;
  localparam int LOSS_NS = 4000;
  localparam int LOSS_CYC = LOSS_NS * (PCLK_KHZ / 1000) / 1000;
  localparam int LOCK_FRAMES = 2;

endpackage

// ### sap_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the pclk domain
// Assumes: Inputs change asynchronously to pclk
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module sap_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sap_sync_state_t;

  sap_sync_state_t s;
  sap_sync_state_t next_s;

  always_comb begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule
`default_nettype wire

// ### sap_port_top.sv
// Purpose: Serial audio port: two-channel/TDM receiver and transmitter with APB registers
// Assumes: Source drives bit clock, word clock and data; processed audio arrives on pclk
// Notes: Bit clock is oversampled by pclk; the lock tracker stands in for the core clock PLL
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// [RULE_01] Core runs only while locked to incoming bit and word clocks; no master clock.
// [RULE_02] Bit clock period is measured; rates above 24.576 MHz flag an error.
// [RULE_03] Source runs bit clock at rate times slot size times channel count.
// [RULE_04] Two-channel and TDM streams at 32 to 192 kHz are accepted.
// [RULE_05] Data word length of 16, 24 or 32 bits set by data size.
// [RULE_06] Port only listens to bit clock and word clock, never drives them.
// [RULE_07] Up to sixteen slots per frame on the single data line.
// [RULE_08] Frame begins at chosen word clock edge; other transitions ignored.
// [RULE_09] Slots counted between frame starts become the detected channel count.
// [RULE_10] Detection works only when format settings match the source.
// [RULE_11] Alignment of data within each slot is set by software.
// [RULE_12] Input map picks which received slots feed processing channels.
// [RULE_13] Output uses the same slot, data, alignment, polarity, edge, bit order.
// [RULE_14] Output data driven only while transmit enable is set.
// [RULE_15] Each of sixteen output slots picks its source; default channels one, two.
// [RULE_16] Lost clocks halt the core and flag lock loss; resumes on return.
// [RULE_17] Malformed frames flag an input error on its own bit.
// [RULE_18] Standard alignment is left-aligned, one bit late, any channel count.
// [RULE_19] Data sampled on polarity-selected edge, MSB first unless LSB first set.
module sap_port_top #(
  parameter int MAX_SLOTS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock_pin,
  input wire logic frame_word_clock_pin,
  input wire logic serial_audio_in_pin,
  output logic serial_audio_out_pin,
  output logic serial_audio_out_oe,
  input wire logic [31:0] proc_ch1_data,
  input wire logic [31:0] proc_ch2_data,
  output logic [31:0] rx_ch0_data,
  output logic [31:0] rx_ch1_data,
  output logic rx_valid,
  output logic core_run,
  output logic irq
);

  // ==========================================================
  // Elaboration check
  if (MAX_SLOTS < 2 || MAX_SLOTS > 16) begin : g_bad_slots
    $error("MAX_SLOTS must lie between 2 and 16");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] ctrl;
    logic [7:0] in_map;
    logic [63:0] out_map;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic bclk_prev;
    logic bclk_seen;
    logic [9:0] per_cnt;
    logic [9:0] bclk_per;
    logic wclk_prev;
    logic [4:0] slot;
    logic [4:0] sbit;
    logic [31:0] shreg;
    logic [31:0] ch0;
    logic [31:0] ch1;
    logic [4:0] chan_cnt;
    logic [1:0] good_frames;
    logic seen_start;
    logic locked;
    logic [31:0] rx_ch0_data;
    logic [31:0] rx_ch1_data;
    logic rx_valid;
    logic sdo;
    logic sdo_oe;
  } sap_state_t;

  sap_state_t s;
  sap_state_t next_s;

  logic [2:0] pins_sync;

  // [RULE_06] Clock pins are inputs only
  sap_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_audio_in_pin, frame_word_clock_pin, bit_clock_pin}),
    .sync_out(pins_sync)
  );

  // ==========================================================
  // Helpers
  // [RULE_05] Size code to bit count
  function automatic logic [5:0] sap_size(input logic [1:0] code);
    if (code == sap_pkg::SIZE_16) begin
      return 6'd16;
    end else if (code == sap_pkg::SIZE_24) begin
      return 6'd24;
    end else begin
      return 6'd32;
    end
  endfunction

  // [RULE_11] Slot bit to word bit; [5] marks a data bit, word is MSB-aligned
  function automatic logic [5:0] sap_bit_pos(input logic [4:0] sbit, input logic [5:0] ss,
                                            input logic [5:0] ds, input logic [1:0] al,
                                            input logic lsb);
    logic [5:0] off;
    logic [5:0] k;
    logic [5:0] p;
    off = (al == sap_pkg::ALIGN_RIGHT) ? 6'(ss - ds) : 6'd0;
    k = 6'({1'b0, sbit} - off);
    // [RULE_19] Bit order select
    p = lsb ? 6'(6'd32 - ds + k) : 6'(6'd31 - k);
    return {({1'b0, sbit} >= off) && (k < ds), p[4:0]};
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic bclk;
    logic wclk;
    logic din;
    logic rise;
    logic fall;
    logic sample;
    logic launch;
    logic fs;
    logic i2s;
    logic [5:0] ss;
    logic [5:0] ds;
    logic [5:0] bp;
    logic [4:0] cslot;
    logic [4:0] csbit;
    logic [4:0] nslot;
    logic [4:0] nsbit;
    logic [4:0] chk_slot;
    logic [4:0] chk_sbit;
    logic do_check;
    logic frame_ok;
    logic loss;
    logic [2:0] ev;
    logic [31:0] word;
    logic [4:0] tslot;
    logic [3:0] src;
    logic [31:0] tword;
    logic setup;
    logic wr;
    logic [2:0] w1c;

    next_s = s;
    bclk = pins_sync[0];
    wclk = pins_sync[1];
    din = pins_sync[2];
    rise = bclk && !s.bclk_prev;
    fall = !bclk && s.bclk_prev;
    sample = s.ctrl[sap_pkg::CTRL_SCK_POL] ? fall : rise;
    launch = s.ctrl[sap_pkg::CTRL_SCK_POL] ? rise : fall;
    i2s = (s.ctrl[sap_pkg::CTRL_ALIGN_LSB +: 2] == sap_pkg::ALIGN_I2S);
    ss = sap_size(s.ctrl[sap_pkg::CTRL_SLOT_LSB +: 2]);
    ds = sap_size(s.ctrl[sap_pkg::CTRL_DATA_LSB +: 2]);
    fs = 1'b0;
    bp = 6'd0;
    cslot = s.slot;
    csbit = s.sbit;
    nslot = s.slot;
    nsbit = s.sbit;
    chk_slot = 5'd0;
    chk_sbit = 5'd0;
    do_check = 1'b0;
    frame_ok = 1'b0;
    loss = 1'b0;
    ev = 3'b000;
    word = 32'h0000_0000;
    tslot = 5'd0;
    src = 4'h0;
    tword = 32'h0000_0000;
    next_s.bclk_prev = bclk;
    next_s.rx_valid = 1'b0;

    // ========================================================
    // Bit clock watch
    if (s.per_cnt != 10'(sap_pkg::LOSS_CYC)) begin
      next_s.per_cnt = 10'(s.per_cnt + 10'd1);
    end
    // [RULE_16] Bit clock silent too long
    if (s.per_cnt == 10'(sap_pkg::LOSS_CYC - 1)) begin
      loss = 1'b1;
    end

    // ========================================================
    // Receive on the sample edge
    if (sample) begin
      next_s.per_cnt = 10'd0;
      next_s.bclk_seen = 1'b1;
      // [RULE_02] Measured period; too short means the rate is over the limit
      if (s.bclk_seen) begin
        next_s.bclk_per = s.per_cnt;
        if (s.per_cnt < 10'(sap_pkg::BCLK_MIN_CYC - 1)) begin
          ev[sap_pkg::IRQ_INPUT_ERR] = 1'b1;
        end
      end
      next_s.wclk_prev = wclk;
      // [RULE_08] Only the selected word clock edge opens a frame
      fs = s.ctrl[sap_pkg::CTRL_EDGE_SEL] ? (wclk && !s.wclk_prev) : (!wclk && s.wclk_prev);
      // Left or right alignment: frame start bit is slot 0 bit 0
      if (fs && !i2s) begin
        do_check = 1'b1;
        chk_slot = s.slot;
        chk_sbit = s.sbit;
        cslot = 5'd0;
        csbit = 5'd0;
      end
      // [RULE_19] Capture the bit into its word position
      bp = sap_bit_pos(csbit, ss, ds, s.ctrl[sap_pkg::CTRL_ALIGN_LSB +: 2],
                       s.ctrl[sap_pkg::CTRL_LSB_FIRST]);
      word = s.shreg;
      if (bp[5]) begin
        word[bp[4:0]] = din;
      end
      next_s.shreg = word;
      if ({1'b0, csbit} == 6'(ss - 6'd1)) begin
        // [RULE_12] Slot complete: route to processing channels
        if (cslot == {1'b0, s.in_map[3:0]}) begin
          next_s.ch0 = word;
        end
        if (cslot == {1'b0, s.in_map[7:4]}) begin
          next_s.ch1 = word;
        end
        next_s.shreg = 32'h0000_0000;
        nslot = 5'(cslot + 5'd1);
        nsbit = 5'd0;
        // [RULE_16] Word clock missing: more slots than a frame can hold
        if (nslot > 5'(MAX_SLOTS) && !fs) begin
          loss = 1'b1;
        end
      end else begin
        nslot = cslot;
        nsbit = 5'(csbit + 5'd1);
      end
      // [RULE_18] Standard alignment: frame start bit is the previous frame's last
      if (fs && i2s) begin
        do_check = 1'b1;
        chk_slot = nslot;
        chk_sbit = nsbit;
        nslot = 5'd0;
        nsbit = 5'd0;
      end
      next_s.slot = nslot;
      next_s.sbit = nsbit;
      if (do_check) begin
        next_s.seen_start = 1'b1;
        // [RULE_07] One to sixteen whole slots form a good frame
        frame_ok = (chk_sbit == 5'd0) && (chk_slot != 5'd0) && (chk_slot <= 5'(MAX_SLOTS));
        if (!s.seen_start) begin
          next_s.good_frames = 2'd0;
        end else if (!frame_ok) begin
          // [RULE_17] Malformed frame
          ev[sap_pkg::IRQ_INPUT_ERR] = 1'b1;
          next_s.good_frames = 2'd0;
          if (s.locked) begin
            next_s.locked = 1'b0;
            ev[sap_pkg::IRQ_LOCK_LOST] = 1'b1;
          end
        end else if (chk_slot == s.chan_cnt) begin
          if (s.good_frames != 2'(sap_pkg::LOCK_FRAMES - 1)) begin
            next_s.good_frames = 2'(s.good_frames + 2'd1);
          end else if (!s.locked) begin
            // [RULE_01] Stable frames: core may run
            next_s.locked = 1'b1;
            ev[sap_pkg::IRQ_LOCKED] = 1'b1;
          end
        end else begin
          // [RULE_09] New channel count detected
          next_s.chan_cnt = chk_slot;
          next_s.good_frames = 2'd0;
          if (s.locked) begin
            next_s.locked = 1'b0;
            ev[sap_pkg::IRQ_LOCK_LOST] = 1'b1;
          end
        end
        if (s.locked && next_s.locked && frame_ok && !loss) begin
          next_s.rx_ch0_data = next_s.ch0;
          next_s.rx_ch1_data = next_s.ch1;
          next_s.rx_valid = 1'b1;
        end
      end
    end

    // [RULE_16] Clock loss halts the core until frames lock again
    if (loss) begin
      next_s.seen_start = 1'b0;
      next_s.good_frames = 2'd0;
      next_s.bclk_seen = 1'b0;
      next_s.slot = 5'd0;
      next_s.sbit = 5'd0;
      next_s.shreg = 32'h0000_0000;
      if (s.locked) begin
        next_s.locked = 1'b0;
        ev[sap_pkg::IRQ_LOCK_LOST] = 1'b1;
      end
    end

    // ========================================================
    // Transmit on the launch edge
    // [RULE_14] Drive only while enabled and running
    next_s.sdo_oe = s.ctrl[sap_pkg::CTRL_TX_EN] && s.locked;
    if (!next_s.sdo_oe) begin
      next_s.sdo = 1'b0;
    end else if (launch) begin
      // Predict the wrap so the first bit of a new frame is ready in time
      tslot = (s.slot == s.chan_cnt) ? 5'd0 : s.slot;
      // [RULE_15] Per-slot source select
      src = s.out_map[{tslot[3:0], 2'b00} +: 4];
      if (src == sap_pkg::SRC_PROC1) begin
        tword = proc_ch1_data;
      end else if (src == sap_pkg::SRC_PROC2) begin
        tword = proc_ch2_data;
      end
      // [RULE_13] Same format settings as the receiver
      bp = sap_bit_pos(s.sbit, ss, ds, s.ctrl[sap_pkg::CTRL_ALIGN_LSB +: 2],
                       s.ctrl[sap_pkg::CTRL_LSB_FIRST]);
      next_s.sdo = bp[5] && (tslot < 5'(MAX_SLOTS)) ? tword[bp[4:0]] : 1'b0;
    end

    // ========================================================
    // APB slave, zero wait states
    next_s.pready = 1'b1;
    setup = psel && !penable;
    wr = psel && penable && pwrite && s.pready;
    w1c = 3'b000;
    if (setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (paddr == sap_pkg::ADDR_CTRL) begin
        next_s.prdata = {22'h00_0000, s.ctrl};
      end else if (paddr == sap_pkg::ADDR_IN_MAP) begin
        next_s.prdata = {24'h00_0000, s.in_map};
      end else if (paddr == sap_pkg::ADDR_OUT_MAP_LO) begin
        next_s.prdata = s.out_map[31:0];
      end else if (paddr == sap_pkg::ADDR_OUT_MAP_HI) begin
        next_s.prdata = s.out_map[63:32];
      end else if (paddr == sap_pkg::ADDR_STATUS) begin
        next_s.prdata = {6'h00, s.bclk_per, 10'h000, s.chan_cnt, s.locked};
      end else if (paddr == sap_pkg::ADDR_IRQ_STAT) begin
        next_s.prdata = {29'h0000_0000, s.irq_stat};
      end else if (paddr == sap_pkg::ADDR_IRQ_MASK) begin
        next_s.prdata = {29'h0000_0000, s.irq_mask};
      end else if (paddr == sap_pkg::ADDR_RX_CH0) begin
        next_s.prdata = s.rx_ch0_data;
      end else if (paddr == sap_pkg::ADDR_RX_CH1) begin
        next_s.prdata = s.rx_ch1_data;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr) begin
      if (paddr == sap_pkg::ADDR_CTRL) begin
        // [RULE_10] Format must match the source for detection to hold
        next_s.ctrl = pwdata[sap_pkg::CTRL_W-1:0];
      end else if (paddr == sap_pkg::ADDR_IN_MAP) begin
        next_s.in_map = pwdata[7:0];
      end else if (paddr == sap_pkg::ADDR_OUT_MAP_LO) begin
        next_s.out_map[31:0] = pwdata;
      end else if (paddr == sap_pkg::ADDR_OUT_MAP_HI) begin
        next_s.out_map[63:32] = pwdata;
      end else if (paddr == sap_pkg::ADDR_IRQ_STAT) begin
        w1c = pwdata[sap_pkg::IRQ_W-1:0];
      end else if (paddr == sap_pkg::ADDR_IRQ_MASK) begin
        next_s.irq_mask = pwdata[sap_pkg::IRQ_W-1:0];
      end
    end

    // Sticky events: a new event wins over a clear in the same cycle
    next_s.irq_stat = (s.irq_stat & ~w1c) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= sap_pkg::CTRL_RESET;
      s.in_map <= sap_pkg::IN_MAP_RESET;
      s.out_map <= {sap_pkg::OUT_MAP_HI_RESET, sap_pkg::OUT_MAP_LO_RESET};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign serial_audio_out_pin = s.sdo;
  assign serial_audio_out_oe = s.sdo_oe;
  assign rx_ch0_data = s.rx_ch0_data;
  assign rx_ch1_data = s.rx_ch1_data;
  assign rx_valid = s.rx_valid;
  assign core_run = s.locked;
  assign irq = s.irq;

endmodule
`default_nettype wire

// ### sap_port_properties.sv
// Purpose: Concurrent checks on the serial audio port pins and APB
// Assumes: One pclk domain, presetn async active low
// Notes: Figures are pclk cycles at 250 MHz
`timescale 1ns/1ns
`default_nettype none
module sap_port_properties #(
  parameter int MAX_SLOTS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic bit_clock_pin,
  input wire logic serial_audio_out_pin,
  input wire logic serial_audio_out_oe,
  input wire logic [31:0] rx_ch0_data,
  input wire logic [31:0] rx_ch1_data,
  input wire logic rx_valid,
  input wire logic core_run,
  input wire logic irq
);
  // ==========
  // Helper logic
  // Idle count saturates so a long stop stays visible
  logic bck_q;
  logic [10:0] idle;
  logic mapped;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= sap_pkg::ADDR_RX_CH1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bck_q <= 1'b0;
      idle <= 11'h000;
    end else begin
      bck_q <= bit_clock_pin;
      if (bit_clock_pin != bck_q) begin
        idle <= 11'h000;
      end else if (idle != 11'h7FF) begin
        idle <= idle + 11'h001;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_mask_clear;
    psel && penable && pwrite && paddr == sap_pkg::ADDR_IRQ_MASK && pwdata[2:0] == 3'h0;
  endsequence
  // ==========
  // Assertions
  a_err_unmapped: assert property (s_access |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_rd_unmapped: assert property (s_access ##0 !pwrite && !mapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_mask_irq: assert property (s_mask_clear |=> ##[0:1] !irq)
    else $error("irq stays high with mask cleared");
  a_oe_halt: assert property ($fell(core_run) |-> ##[0:2] !serial_audio_out_oe)
    else $error("output still driven after lock loss");
  a_out_idle: assert property (!serial_audio_out_oe && !$past(serial_audio_out_oe)
    |-> !serial_audio_out_pin)
    else $error("output data active while not driving");
  a_valid_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  a_valid_locked: assert property (rx_valid |-> core_run)
    else $error("rx_valid while not locked");
  a_rx_hold: assert property (!rx_valid |-> $stable(rx_ch0_data) && $stable(rx_ch1_data))
    else $error("received words changed without rx_valid");
  a_loss_halt: assert property (idle == 11'h410 |-> !core_run)
    else $error("core runs with bit clock stopped");
  a_run_clock: assert property ($rose(core_run) |-> idle < 11'h020)
    else $error("lock gained without bit clock activity");
endmodule
bind sap_port_top sap_port_properties #(.MAX_SLOTS(MAX_SLOTS)) u_props (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pslverr,
  .bit_clock_pin, .serial_audio_out_pin, .serial_audio_out_oe, .rx_ch0_data,
  .rx_ch1_data, .rx_valid, .core_run, .irq
);
`default_nettype wire

// ### sap_src_model.sv
// Purpose: Behavioural audio source driving bit clock, word clock and data
// Assumes: Two-channel style framing, falling frame edge, MSB first
// Notes: Bit clock 80 ns, stands still between runs
`timescale 1ns/1ns
`default_nettype none
module sap_src_model (
  input wire logic run,
  input wire logic extra,
  input wire logic [4:0] nslot,
  input wire logic [15:0][31:0] words,
  output logic bit_clock_pin,
  output logic frame_word_clock_pin,
  output logic serial_audio_in_pin,
  output logic [9:0] pos
);
  int f;
  initial begin
    bit_clock_pin = 1'b0;
    frame_word_clock_pin = 1'b0;
    serial_audio_in_pin = 1'b0;
    pos = 10'h000;
    forever begin
      if (!run) begin
        serial_audio_in_pin = ~serial_audio_in_pin;
        wait (run);
        #1;
      end
      f = 32 * int'(nslot) + (extra ? 5 : 0);
      for (int i = 0; i < f; i++) begin
        bit_clock_pin = 1'b0;
        pos = 10'(i);
        frame_word_clock_pin = ((i + 1) % f) >= 32;
        serial_audio_in_pin = words[i / 32][31 - i % 32];
        #40;
        bit_clock_pin = 1'b1;
        #40;
      end
    end
  end
endmodule
`default_nettype wire

// ### sap_port_top_tb.sv
// Purpose: Self-checking bench for the serial audio port
// Assumes: APB with zero wait states accepted but not assumed
// Notes: Register rows first, then lock, tx, TDM, loss and error cases
`timescale 1ns/1ns
`default_nettype none
module sap_port_top_tb;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } sap_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, extra = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rx_ch0_data, rx_ch1_data, rd;
  logic [31:0] proc_ch1_data = 32'h1357_9BDF, proc_ch2_data = 32'h2468_ACE0;
  logic pready, pslverr, bit_clock_pin, frame_word_clock_pin, serial_audio_in_pin, er;
  logic serial_audio_out_pin, serial_audio_out_oe, rx_valid, core_run, irq;
  logic [4:0] nslot = 5'h02;
  logic [15:0][31:0] words;
  logic [9:0] pos;
  logic [127:0] txcap;
  int n_fail = 0, check_count = 0;
  sap_row_t rows [10] = '{
    '{sap_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'h0000_000A, 1'b0},
    '{sap_pkg::ADDR_IN_MAP, 1'b0, 32'h0, 32'h0000_0010, 1'b0},
    '{sap_pkg::ADDR_OUT_MAP_LO, 1'b0, 32'h0, 32'h0000_0021, 1'b0},
    '{sap_pkg::ADDR_OUT_MAP_HI, 1'b0, 32'h0, 32'h0, 1'b0},
    '{sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h0, 1'b0},
    '{sap_pkg::ADDR_IRQ_MASK, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h024, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b1},
    '{sap_pkg::ADDR_RX_CH0, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{sap_pkg::ADDR_OUT_MAP_HI, 1'b1, 32'h8765_4321, 32'h8765_4321, 1'b0},
    '{sap_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0007, 32'h0000_0007, 1'b0}};
  always #2 pclk = ~pclk;
  sap_port_top u_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .bit_clock_pin, .frame_word_clock_pin, .serial_audio_in_pin,
    .serial_audio_out_pin, .serial_audio_out_oe, .proc_ch1_data, .proc_ch2_data,
    .rx_ch0_data, .rx_ch1_data, .rx_valid, .core_run, .irq
  );
  sap_src_model u_src (
    .run, .extra, .nslot, .words, .bit_clock_pin, .frame_word_clock_pin,
    .serial_audio_in_pin, .pos
  );
  // Transmit capture at sample edges; slot 0 lands in the top word
  always @(posedge bit_clock_pin) begin
    if (pos < 10'h080) begin
      txcap[7'h7F - pos[6:0]] <= serial_audio_out_pin;
    end
  end
  // ==========
  // Tasks
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 100) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic wait_on(input int sel, input logic v);
    int k;
    k = 0;
    while (k < 20000 && (sel == 0 ? core_run : rx_valid) !== v) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20000) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      wait_on(1, 1'b1);
      @(posedge pclk);
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    words = '0;
    words[0] = 32'hA5C3_0F01;
    words[1] = 32'h5A3C_F0E2;
    words[2] = 32'h0123_4567;
    words[3] = 32'h89AB_CDEF;
    repeat (8) @(posedge pclk);
    chk(32'({pready, core_run, irq, serial_audio_out_oe}), 32'h0);
    presetn <= 1'b1;
    foreach (rows[n]) begin
      if (rows[n].w) apb(rows[n].a, 1'b1, rows[n].d);
      apb(rows[n].a, 1'b0, 32'h0);
      chk(rd, rows[n].x);
      chk(32'(er), 32'(rows[n].e));
    end
    run <= 1'b1;
    wait_on(0, 1'b1);
    frames(1);
    chk(rx_ch0_data, words[0]);
    chk(rx_ch1_data, words[1]);
    chk(32'(serial_audio_out_oe), 32'h0);
    apb(sap_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(32'(rd[5:0]), 32'h0000_0005);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(32'({rd[2], irq}), 32'h0000_0003);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b1, 32'h0000_0007);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(32'({rd[2:0], irq}), 32'h0);
    apb(sap_pkg::ADDR_CTRL, 1'b1, 32'h0000_020A);
    frames(2);
    chk(32'(serial_audio_out_oe), 32'h0000_0001);
    chk(txcap[127:96], proc_ch1_data);
    chk(txcap[95:64], proc_ch2_data);
    apb(sap_pkg::ADDR_IN_MAP, 1'b1, 32'h0000_0032);
    apb(sap_pkg::ADDR_OUT_MAP_LO, 1'b1, 32'h0000_1200);
    nslot <= 5'h04;
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    frames(2);
    chk(rx_ch0_data, words[2]);
    chk(rx_ch1_data, words[3]);
    chk(txcap[127:64] == 64'h0 ? txcap[63:32] : 32'h0, proc_ch2_data);
    chk(txcap[31:0], proc_ch1_data);
    apb(sap_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(32'(rd[5:0]), 32'h0000_0009);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b1, 32'h0000_0007);
    apb(sap_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0002);
    run <= 1'b0;
    wait_on(0, 1'b0);
    @(posedge pclk);
    chk(32'(serial_audio_out_oe), 32'h0);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(32'({rd[0], irq}), 32'h0000_0002);
    apb(sap_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0007);
    @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b1, 32'h0000_0007);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(32'(irq), 32'h0);
    run <= 1'b1;
    wait_on(0, 1'b1);
    extra <= 1'b1;
    wait_on(0, 1'b0);
    apb(sap_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(32'(rd[1]), 32'h0000_0001);
    apb(sap_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
